// ---- core/adc_seq_pkg.sv ----
/*
 Package for the integrating converter sequencer: host address decode,
 status and byte layouts, phase lengths and sequencer states.
 Assumes the users import the whole package.
*/
package adc_seq_pkg;

	// ----------------------------------------------------------------
	// Host address decode (addr_hi_bit, addr_lo_bit)
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_SETUP  = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h0;
	localparam logic [1:0] ADDR_UPPER  = 2'h1;
	localparam logic [1:0] ADDR_TEST   = 2'h3;

	// ----------------------------------------------------------------
	// Setup and status byte fields
	// ----------------------------------------------------------------
	localparam int SETUP_CHAN_LSB = 0;
	localparam int SETUP_RES_BIT  = 3;
	localparam int SETUP_FLAG_BIT = 7;
	localparam int STAT_EOC_BIT   = 7;
	localparam int STAT_BUSY_BIT  = 6;

	// ----------------------------------------------------------------
	// Conversion timing and sizes
	// ----------------------------------------------------------------
	localparam int RESULT_WIDTH = 12;
	localparam int INTEG_CYCLES = 8192;
	localparam logic [13:0] INTEG_LAST = 14'(INTEG_CYCLES - 1);
	localparam logic [RESULT_WIDTH-1:0] RESULT_MAX = 12'hFFF;
	// Reset values; the real part has none, the state is defined here
	// only so that simulation starts from something known.
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ARMED,
		SEQ_INTEGRATE,
		SEQ_DISCHARGE
	} seq_state_t;

endpackage

// ---- core/adc_bus_decode.sv ----
/*
 Host bus decoder: turns chip select, strobes and two address bits
 into the access that is in progress.
 Assumes host pins are synchronous to the clock.
*/
`timescale 1ns/100ps
module adc_bus_decode
	import adc_seq_pkg::*;
(
	// Host control pins
	input  wire logic       chip_sel_n,
	input  wire logic       read_n,
	input  wire logic       write_n,
	input  wire logic       addr_hi_bit,
	input  wire logic       addr_lo_bit,
	// Decoded accesses
	output logic            setup_wr,
	output logic            test_wr,
	output logic            rd_active,
	output logic [1:0]      rd_addr
);

	logic [1:0] addr;

	assign addr = {addr_hi_bit, addr_lo_bit};

	// Mixed write addresses and idle strobes leave the part unselected.
	assign setup_wr  = !chip_sel_n && read_n && !write_n
		&& addr == ADDR_SETUP;
	assign test_wr   = !chip_sel_n && read_n && !write_n
		&& addr == ADDR_TEST;
	assign rd_active = !chip_sel_n && !read_n && write_n;
	assign rd_addr   = addr;

endmodule

// ---- core/adc_read_mux.sv ----
/*
 Read data multiplexer: picks status, upper or lower result byte.
 Assumes the result and status inputs are registered.
*/
`timescale 1ns/100ps
module adc_read_mux
	import adc_seq_pkg::*;
(
	// Select
	input  wire logic [1:0]              rd_addr,
	// Sources
	input  wire logic [7:0]              status_byte,
	input  wire logic [RESULT_WIDTH-1:0] result,
	// Byte out
	output logic [7:0]                   rd_byte
);

	always_comb begin
		if (rd_addr[1]) begin
			rd_byte = {result[3:0], 4'h0};
		end else if (rd_addr[0]) begin
			rd_byte = result[11:4];
		end else begin
			rd_byte = status_byte;
		end
	end

endmodule

// ---- core/adc_sequencer.sv ----
/*
 Sequencer, host port, result latch and status latch of a four-channel
 integrating converter. The analog integrator lies outside: this block
 drives integrate_on and discharge_on and watches zero_cross.
 Assumes one free running clock and host pins synchronous to it.
*/
`timescale 1ns/100ps
module adc_sequencer
	import adc_seq_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Host bus
	input  wire logic       chip_sel_n,
	input  wire logic       read_n,
	input  wire logic       write_n,
	input  wire logic       addr_hi_bit,
	input  wire logic       addr_lo_bit,
	input  wire logic [7:0] data_in,
	output logic [7:0]      data_out,
	output logic            data_oe,
	output logic            eoc_n,
	// Analog section
	input  wire logic       zero_cross,
	output logic [1:0]      input_channel_sel,
	output logic            integrate_on,
	output logic            discharge_on,
	output logic            res_10bit
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		seq_state_t              state;
		logic [13:0]             timer;
		logic [RESULT_WIDTH-1:0] count;
		logic [RESULT_WIDTH-1:0] result;
		logic [1:0]              channel;
		logic                    res10;
		logic                    flag;
		logic                    busy;
		logic                    eoc;
		logic                    write_prev;
		logic [7:0]              data_out;
	} regs_t;

	regs_t cur;
	regs_t next_cur;

	logic             setup_wr;
	logic             test_wr;
	logic             rd_active;
	logic [1:0]       rd_addr;
	logic [7:0]       status_byte;
	logic [7:0]       rd_byte;
	logic             done;
	logic             upper_rd;

	adc_bus_decode adc_bus_decode_inst (
		.chip_sel_n  (chip_sel_n),
		.read_n      (read_n),
		.write_n     (write_n),
		.addr_hi_bit (addr_hi_bit),
		.addr_lo_bit (addr_lo_bit),
		.setup_wr    (setup_wr),
		.test_wr     (test_wr),
		.rd_active   (rd_active),
		.rd_addr     (rd_addr)
	);

	assign status_byte = {cur.eoc, cur.busy, cur.result[11:10],
		cur.res10, cur.flag, cur.channel};

	adc_read_mux adc_read_mux_inst (
		.rd_addr     (rd_addr),
		.status_byte (status_byte),
		.result      (cur.result),
		.rd_byte     (rd_byte)
	);

	// A discharge count that saturates still ends the conversion, so a
	// missing zero crossing cannot hang the sequencer.
	assign done = cur.state == SEQ_DISCHARGE
		&& (zero_cross || cur.count == RESULT_MAX);
	assign upper_rd = rd_active && rd_addr == ADDR_UPPER;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.write_prev = !write_n;
		next_cur.data_out = rd_byte;
		case (cur.state)
			SEQ_IDLE: begin
			end
			SEQ_ARMED: begin
				// Waits for the write strobe to rise.
				if (!setup_wr) begin
					next_cur.state = SEQ_INTEGRATE;
					next_cur.timer = '0;
				end
			end
			SEQ_INTEGRATE: begin
				next_cur.timer = cur.timer + 14'h0001;
				if (cur.timer == INTEG_LAST) begin
					next_cur.state = SEQ_DISCHARGE;
					next_cur.count = '0;
				end
			end
			SEQ_DISCHARGE: begin
				next_cur.count = cur.count + 12'h001;
				if (done) begin
					next_cur.state  = SEQ_IDLE;
					// All 12 bits latch whatever the resolution.
					next_cur.result = cur.count;
					next_cur.busy   = 1'b0;
				end
			end
			default: begin
				next_cur.state = SEQ_IDLE;
			end
		endcase
		// Upper byte read clears, completion sets; set wins.
		if (upper_rd) begin
			next_cur.eoc = 1'b0;
		end
		if (done) begin
			next_cur.eoc = 1'b1;
		end
		if (test_wr) begin
			next_cur.count = {data_in, 4'h0};
		end
		if (setup_wr) begin
			next_cur.channel = data_in[SETUP_CHAN_LSB +: 2];
			next_cur.res10   = data_in[SETUP_RES_BIT];
			next_cur.flag    = data_in[SETUP_FLAG_BIT];
			next_cur.busy    = 1'b1;
			next_cur.state   = SEQ_ARMED;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cur.state      <= SEQ_IDLE;
			cur.timer      <= '0;
			cur.count      <= '0;
			cur.result     <= RESULT_RESET;
			cur.channel    <= STATUS_RESET[1:0];
			cur.res10      <= 1'b0;
			cur.flag       <= 1'b0;
			cur.busy       <= 1'b0;
			cur.eoc        <= 1'b0;
			cur.write_prev <= 1'b0;
			cur.data_out   <= 8'h00;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign data_out          = cur.data_out;
	assign data_oe           = rd_active;
	assign eoc_n             = !cur.eoc;
	assign input_channel_sel = cur.channel;
	assign integrate_on      = cur.state == SEQ_INTEGRATE;
	assign discharge_on      = cur.state == SEQ_DISCHARGE;
	assign res_10bit         = cur.res10;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	int integ_run;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			integ_run <= 0;
		end else if (integrate_on) begin
			integ_run <= integ_run + 1;
		end else begin
			integ_run <= 0;
		end
	end

	property p_integ_len;
		@(posedge clock) disable iff (reset)
		// A setup write may cut integration short; only a fall into
		// discharge marks a full integration phase.
		$fell(integrate_on) && discharge_on |-> integ_run == INTEG_CYCLES;
	endproperty
	a_integ_len: assert property (p_integ_len)
		else $error("integration length wrong");

	property p_start_after_write;
		@(posedge clock) disable iff (reset)
		setup_wr |=> !integrate_on;
	endproperty
	a_start_after_write: assert property (p_start_after_write)
		else $error("integration began during the write");

	property p_arm_start;
		@(posedge clock) disable iff (reset)
		setup_wr ##1 !setup_wr |=> integrate_on;
	endproperty
	a_arm_start: assert property (p_arm_start)
		else $error("no start at write strobe rise");

	property p_busy_set;
		@(posedge clock) disable iff (reset)
		setup_wr |=> status_byte[STAT_BUSY_BIT];
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("busy not set by setup write");

	property p_done_latch;
		@(posedge clock) disable iff (reset)
		done && !setup_wr && !test_wr |=> cur.result == $past(cur.count)
			&& !eoc_n && !cur.busy;
	endproperty
	a_done_latch: assert property (p_done_latch)
		else $error("result or flags wrong at completion");

	property p_result_hold;
		@(posedge clock) disable iff (reset)
		!done |=> $stable(cur.result);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("result changed without completion");

	property p_eoc_clear;
		@(posedge clock) disable iff (reset)
		upper_rd && !done |=> eoc_n;
	endproperty
	a_eoc_clear: assert property (p_eoc_clear)
		else $error("upper read did not clear eoc");

	property p_float;
		@(posedge clock) disable iff (reset)
		chip_sel_n || (read_n && write_n) |-> !data_oe;
	endproperty
	a_float: assert property (p_float)
		else $error("data driven while unselected");

	property p_upper_data;
		@(posedge clock) disable iff (reset)
		upper_rd |=> data_out == $past(cur.result[11:4]);
	endproperty
	a_upper_data: assert property (p_upper_data)
		else $error("upper byte wrong");

	property p_strobe_rise;
		@(posedge clock) disable iff (reset)
		cur.state == SEQ_ARMED && cur.write_prev && write_n |=> integrate_on;
	endproperty
	a_strobe_rise: assert property (p_strobe_rise)
		else $error("write strobe rise did not start integration");

	property p_test_load;
		@(posedge clock) disable iff (reset)
		test_wr |=> cur.count == {$past(data_in), 4'h0};
	endproperty
	a_test_load: assert property (p_test_load)
		else $error("test write did not load the counter");

	property p_setup_fields;
		@(posedge clock) disable iff (reset)
		setup_wr |=> input_channel_sel == $past(data_in[SETUP_CHAN_LSB +: 2])
			&& res_10bit == $past(data_in[SETUP_RES_BIT]);
	endproperty
	a_setup_fields: assert property (p_setup_fields)
		else $error("channel or resolution not taken from setup byte");

	property p_status_out;
		@(posedge clock) disable iff (reset)
		rd_active && rd_addr == ADDR_STATUS
			|=> data_out == $past(status_byte);
	endproperty
	a_status_out: assert property (p_status_out)
		else $error("status byte wrong");

endmodule

// ---- verif/host_model.sv ----
/*
 Host processor model: writes the setup byte and reads bytes back over
 the parallel bus. Assumes a device that answers one edge after a read.
*/
`timescale 1ns/100ps
module host_model (
	// Clock
	input  wire logic       clock,
	// Device answer
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	// Bus pins
	output logic            chip_sel_n,
	output logic            read_n,
	output logic            write_n,
	output logic            addr_hi_bit,
	output logic            addr_lo_bit,
	output logic [7:0]      data_in
);
	logic       drive;
	logic [7:0] wdata;
	logic [7:0] last;

	// A released bus shows the inverse of the last byte, so a stale
	// value can never pass for a fresh answer.
	assign data_in = drive ? wdata : (data_oe ? data_out : ~last);

	initial begin
		{chip_sel_n, read_n, write_n} = 3'h7;
		{addr_hi_bit, addr_lo_bit} = 2'h0;
		{drive, wdata, last} = 17'h0;
	end

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		{addr_hi_bit, addr_lo_bit} = a;
		{drive, wdata} = {1'b1, d};
		{chip_sel_n, write_n} = 2'h0;
		@(posedge clock);
		#1;
		{chip_sel_n, write_n, drive} = 3'h6;
		last = d;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clock);
		#1;
		{addr_hi_bit, addr_lo_bit} = a;
		{chip_sel_n, read_n} = 2'h0;
		repeat (2) @(posedge clock);
		d = data_in;
		#1;
		{chip_sel_n, read_n} = 2'h3;
		last = d;
	endtask
endmodule

// ---- verif/tb_integrating_adc_host_sequencer.sv ----
/*
 Testbench for the converter sequencer: setup writes, timed phases,
 result and status reads. Assumes the host model drives the bus pins.
*/
`timescale 1ns/100ps
module tb_integrating_adc_host_sequencer;
	import adc_seq_pkg::*;
	logic        clock, reset, zero_cross;
	logic        chip_sel_n, read_n, write_n, addr_hi_bit, addr_lo_bit;
	logic [7:0]  data_in, data_out;
	logic        data_oe, eoc_n, integrate_on, discharge_on, res_10bit;
	logic [1:0]  input_channel_sel;
	logic [11:0] prev, r1, r2;
	int          mismatches, checks;

	adc_sequencer adc_sequencer_inst (.clock(clock), .reset(reset),
		.chip_sel_n(chip_sel_n), .read_n(read_n), .write_n(write_n),
		.addr_hi_bit(addr_hi_bit), .addr_lo_bit(addr_lo_bit),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.eoc_n(eoc_n), .zero_cross(zero_cross),
		.input_channel_sel(input_channel_sel),
		.integrate_on(integrate_on), .discharge_on(discharge_on),
		.res_10bit(res_10bit));
	host_model host_model_inst (.clock(clock), .data_out(data_out),
		.data_oe(data_oe), .chip_sel_n(chip_sel_n), .read_n(read_n),
		.write_n(write_n), .addr_hi_bit(addr_hi_bit),
		.addr_lo_bit(addr_lo_bit), .data_in(data_in));

	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_idle;
		logic [7:0] s;
		chk(16'(data_oe), 16'h0);
		host_model_inst.wr(2'h1, 8'h8F);
		host_model_inst.wr(2'h2, 8'h8F);
		host_model_inst.rd(2'h0, s);
		chk(16'(s), 16'(STATUS_RESET));
		chk(16'(eoc_n), 16'h1);
		$display("idle test done");
	endtask

	task automatic conv(input logic [1:0] ch, input logic rs,
		input int n, output logic [11:0] r);
		logic [7:0] s, u, u2, l, l2;
		int k;
		host_model_inst.wr(2'h0, {1'b1, 3'h0, rs, 1'b0, ch});
		chk(16'(integrate_on), 16'h0);
		k = 0;
		while (integrate_on !== 1'b1 && k < 4) begin
			@(posedge clock);
			#1;
			k++;
		end
		chk(16'(k), 16'h1);
		chk(16'({input_channel_sel, res_10bit}), 16'({ch, rs}));
		k = 0;
		while (integrate_on === 1'b1 && k < 9000) begin
			@(posedge clock);
			#1;
			k++;
		end
		chk(16'(k), 16'(INTEG_CYCLES));
		chk(16'(discharge_on), 16'h1);
		host_model_inst.rd(2'h0, s);
		chk(16'(s), 16'({2'b01, prev[11:10], rs, 1'b1, ch}));
		repeat (n) @(posedge clock);
		#1;
		zero_cross = 1;
		k = 0;
		while (eoc_n !== 1'b0 && k < 20) begin
			@(posedge clock);
			#1;
			k++;
		end
		zero_cross = 0;
		chk(16'({eoc_n, discharge_on}), 16'h0);
		host_model_inst.rd(2'h2, l);
		host_model_inst.rd(2'h3, l2);
		chk(16'(l2), 16'(l));
		chk(16'(l[3:0]), 16'h0);
		host_model_inst.rd(2'h0, s);
		host_model_inst.rd(2'h1, u);
		chk(16'(s), 16'({2'b10, u[7:6], rs, 1'b1, ch}));
		chk(16'(eoc_n), 16'h1);
		// Second upper byte read must return the same byte as the first.
		host_model_inst.rd(2'h1, u2);
		chk(16'(u2), 16'(u));
		host_model_inst.rd(2'h0, s);
		chk(16'(s[7:6]), 16'h0);
		r = {u, l[7:4]};
		prev = r;
		$display("conversion test done on channel %0d", ch);
	endtask

	task automatic t_test_mode;
		logic [7:0] s, u, l;
		int k;
		host_model_inst.wr(2'h0, 8'h02);
		k = 0;
		while (discharge_on !== 1'b1 && k < 9000) begin
			@(posedge clock);
			#1;
			k++;
		end
		chk(16'(k), 16'(INTEG_CYCLES + 1));
		// The counter is loaded from the data pins, then ends at once.
		host_model_inst.wr(2'h3, 8'hA5);
		zero_cross = 1;
		@(posedge clock);
		#1;
		zero_cross = 0;
		chk(16'(eoc_n), 16'h0);
		host_model_inst.rd(2'h0, s);
		chk(16'(s), 16'hA2);
		host_model_inst.rd(2'h1, u);
		host_model_inst.rd(2'h2, l);
		chk(16'({u, l}), 16'hA500);
		$display("test mode test done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{mismatches, checks} = 0;
		{reset, zero_cross} = 2'h2;
		prev = RESULT_RESET;
		// The oscillator settling wait is shortened to the reset span.
		repeat (12) @(posedge clock);
		#1;
		reset = 0;
		t_idle();
		conv(2'h0, 1'b0, 20, r1);
		conv(2'h1, 1'b1, 520, r2);
		chk(16'(r2 - r1), 16'h01F4);
		conv(2'h2, 1'b0, 1500, r1);
		chk(16'(r1 - r2), 16'h03D4);
		conv(2'h3, 1'b1, 3000, r2);
		chk(16'(r2 - r1), 16'h05DC);
		t_test_mode();
		end_of_test();
	end

	initial begin
		repeat (60000) @(posedge clock);
		mismatches++;
		end_of_test();
	end
endmodule
